// file: rtl/lcd_timing_pkg.sv
package lcd_timing_pkg;

  // ----------------------------------------
  // Register map (printed offsets are not multiples of four: index * 4)
  // ----------------------------------------
  localparam logic [7:0] idx_display_ctrl = 8'h13;
  localparam logic [7:0] idx_duty_clock_ctrl = 8'h14;
  localparam logic [7:0] idx_segment_port_select = 8'h15;
  localparam logic [7:0] idx_timer_mode = 8'h08;
  localparam logic [7:0] idx_status = 8'h30;
  localparam logic [9:0] addr_display_ctrl = {idx_display_ctrl, 2'b00};
  localparam logic [9:0] addr_duty_clock_ctrl = {idx_duty_clock_ctrl, 2'b00};
  localparam logic [9:0] addr_segment_port_select = {idx_segment_port_select, 2'b00};
  localparam logic [9:0] addr_timer_mode = {idx_timer_mode, 2'b00};
  localparam logic [9:0] addr_status = {idx_status, 2'b00};

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int disp_blank_bit = 0;
  localparam int disp_power_bit = 1;
  localparam int disp_watch_bit = 2;
  localparam int timer_a_mode_bit3_pos = 3;
  localparam logic [2:0] display_ctrl_reset = 3'h0;
  localparam logic [3:0] duty_clock_ctrl_reset = 4'h0;
  localparam logic [3:0] segment_port_select_reset = 4'h0;
  localparam logic [3:0] timer_mode_reset = 4'h0;

  // ----------------------------------------
  // Division ratios
  // ----------------------------------------
  localparam int div_osc_clk0 = 64;
  localparam int div_cyc_clk1 = 256;
  localparam int div_cyc_clk2 = 2048;
  localparam int div_cyc_clk3 = 4096;
  localparam int div_osc_clk3 = 512;

  // Cycle clock period and its length in aclk cycles (10 MHz)
  localparam int cycle_time_ns = 2000;
  localparam int aclk_period_ns = 100;
  localparam int cyc_div_cycles = (cycle_time_ns + aclk_period_ns - 1) / aclk_period_ns;

  // Duty and clock selection codes
  typedef enum logic [1:0] {
    duty_quarter = 2'b00,
    duty_third = 2'b01,
    duty_half = 2'b10,
    duty_static = 2'b11
  } duty_e;

  typedef enum logic [1:0] {
    sel_osc_div64 = 2'b00,
    sel_cyc_div256 = 2'b01,
    sel_cyc_div2048 = 2'b10,
    sel_fourth = 2'b11
  } clk_sel_e;

  localparam logic [1:0] axi_okay = 2'b00;
  localparam logic [1:0] axi_slverr = 2'b10;

endpackage

// file: rtl/edge_divider.sv
`timescale 1ns/1ps
// Counts input ticks and pulses once every ratio ticks
module edge_divider
  import lcd_timing_pkg::*;
#(
  parameter int ratio = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick_in,
  output logic tick_out
);

  localparam int cw = (ratio > 1) ? $clog2(ratio) : 1;
  localparam logic [cw-1:0] last = cw'(ratio - 1);

  logic [cw-1:0] count_r;

  // ----------------------------------------
  // Ratio counter
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (count_r == last) begin
          count_r <= '0;
          tick_out <= 1'b1;
        end else begin
          count_r <= count_r + 1'b1;
        end
      end
    end
  end

endmodule

// file: rtl/frame_divider.sv
`timescale 1ns/1ps
// Divides the selected LCD clock tick by the duty's common count
module frame_divider
  import lcd_timing_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic lcd_tick,
  input wire logic [1:0] duty,
  output logic frame_tick,
  output logic [1:0] common_index
);

  logic [1:0] last;

  // Last common index for each duty
  always_comb begin
    unique case (duty)
      duty_quarter: last = 2'd3;
      duty_third: last = 2'd2;
      duty_half: last = 2'd1;
      default: last = 2'd0;
    endcase
  end

  // ----------------------------------------
  // Common phase counter
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      common_index <= 2'd0;
      frame_tick <= 1'b0;
    end else begin
      frame_tick <= 1'b0;
      if (lcd_tick) begin
        if (common_index >= last) begin
          common_index <= 2'd0;
          frame_tick <= 1'b1;
        end else begin
          common_index <= common_index + 2'd1;
        end
      end
    end
  end

endmodule

// file: rtl/lcd_frame_clock.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Frame rate is LCD clock for static, half for 1/2, third for 1/3 duty.
// - With timer-A mode bit three clear, fourth clock is cycle clock over 4096.
// - With timer-A mode bit three set, fourth clock is oscillator over 512.
// - Segment port select register is write-only; reads return zero.
// - Each select bit turns one 4-bit port into four segment lines.
// - Duty/clock register: bits 1:0 duty, bits 3:2 LCD clock source.
// - Power switch bit closes divider power switch; clearing opens it.
module lcd_frame_clock
  import lcd_timing_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_32k,
  input wire logic [3:0] general_port_out,
  input wire logic [15:0] segment_drive,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic lcd_clk_tick,
  output logic frame_tick,
  output logic [1:0] common_index,
  output logic power_switch_on,
  output logic display_on,
  output logic watch_display_on,
  output logic [15:0] segment_line,
  output logic [3:0] segment_port_enable
);

  // ----------------------------------------
  // Registers and internal signals
  // ----------------------------------------
  logic [2:0] display_ctrl_r;
  logic [3:0] duty_clock_ctrl_r;
  logic [3:0] segment_port_select_r;
  logic [3:0] timer_mode_r;
  logic osc_meta_r;
  logic osc_sync_r;
  logic osc_prev_r;
  logic osc_rise;
  logic [$clog2(cyc_div_cycles)-1:0] cyc_count_r;
  logic cyc_tick_r;
  logic tick_osc64, tick_cyc256, tick_cyc2048, tick_cyc4096, tick_osc512;
  logic fourth_tick;
  logic sel_tick;
  logic frame_pulse;
  logic [1:0] common_next;
  logic aw_held_r, w_held_r;
  logic [9:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  logic [31:0] read_word;
  logic read_ok;

  // Exact 10-bit address match for register decode
  function automatic logic word_hit(input logic [9:0] addr, input logic [9:0] target);
    return addr == target;
  endfunction

  // ----------------------------------------
  // Oscillator pin synchroniser and edge detect
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_meta_r <= osc_32k;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end

  assign osc_rise = osc_sync_r & ~osc_prev_r;

  // ----------------------------------------
  // Cycle clock: one tick per instruction cycle
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_count_r <= '0;
      cyc_tick_r <= 1'b0;
    end else begin
      cyc_tick_r <= 1'b0;
      if (cyc_count_r == ($clog2(cyc_div_cycles))'(cyc_div_cycles - 1)) begin
        cyc_count_r <= '0;
        cyc_tick_r <= 1'b1;
      end else begin
        cyc_count_r <= cyc_count_r + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // LCD clock candidates
  // ----------------------------------------
  edge_divider #(.ratio(div_osc_clk0)) u_osc64 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(osc_rise),
    .tick_out(tick_osc64)
  );

  edge_divider #(.ratio(div_cyc_clk1)) u_cyc256 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(cyc_tick_r),
    .tick_out(tick_cyc256)
  );

  edge_divider #(.ratio(div_cyc_clk2)) u_cyc2048 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(cyc_tick_r),
    .tick_out(tick_cyc2048)
  );

  edge_divider #(.ratio(div_cyc_clk3)) u_cyc4096 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(cyc_tick_r),
    .tick_out(tick_cyc4096)
  );

  edge_divider #(.ratio(div_osc_clk3)) u_osc512 (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(osc_rise),
    .tick_out(tick_osc512)
  );

  // Fourth option source picked by the timer-A mode bit
  assign fourth_tick = timer_mode_r[timer_a_mode_bit3_pos] ? tick_osc512 : tick_cyc4096;

  // LCD clock source select
  always_comb begin
    unique case (clk_sel_e'(duty_clock_ctrl_r[3:2]))
      sel_osc_div64: sel_tick = tick_osc64;
      sel_cyc_div256: sel_tick = tick_cyc256;
      sel_cyc_div2048: sel_tick = tick_cyc2048;
      sel_fourth: sel_tick = fourth_tick;
    endcase
  end

  // ----------------------------------------
  // Frame divider by duty
  // ----------------------------------------
  frame_divider u_frame (
    .aclk(aclk),
    .aresetn(aresetn),
    .lcd_tick(sel_tick),
    .duty(duty_clock_ctrl_r[1:0]),
    .frame_tick(frame_pulse),
    .common_index(common_next)
  );

  // Timing outputs registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcd_clk_tick <= 1'b0;
      frame_tick <= 1'b0;
      common_index <= 2'd0;
    end else begin
      lcd_clk_tick <= sel_tick;
      frame_tick <= frame_pulse;
      common_index <= common_next;
    end
  end

  // ----------------------------------------
  // Display control outputs
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_switch_on <= 1'b0;
      display_on <= 1'b0;
      watch_display_on <= 1'b0;
    end else begin
      power_switch_on <= display_ctrl_r[disp_power_bit];
      display_on <= display_ctrl_r[disp_blank_bit];
      watch_display_on <= display_ctrl_r[disp_watch_bit];
    end
  end

  // Port/segment selection per nibble; blanked segments read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      segment_line <= 16'h0000;
      segment_port_enable <= 4'h0;
    end else begin
      segment_port_enable <= segment_port_select_r;
      for (int i = 0; i < 4; i++) begin
        if (segment_port_select_r[i]) begin
          segment_line[i*4 +: 4] <= display_ctrl_r[disp_blank_bit] ? segment_drive[i*4 +: 4] : 4'h0;
        end else begin
          segment_line[i*4 +: 4] <= {4{general_port_out[i]}};
        end
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 10'h000;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= axi_okay;
    end else begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[9:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (word_hit(aw_addr_r, addr_display_ctrl) || word_hit(aw_addr_r, addr_duty_clock_ctrl) ||
                        word_hit(aw_addr_r, addr_segment_port_select) || word_hit(aw_addr_r, addr_timer_mode) ||
                        word_hit(aw_addr_r, addr_status)) ? axi_okay : axi_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register storage, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      display_ctrl_r <= display_ctrl_reset;
      duty_clock_ctrl_r <= duty_clock_ctrl_reset;
      segment_port_select_r <= segment_port_select_reset;
      timer_mode_r <= timer_mode_reset;
    end else if (do_write && w_strb_r[0]) begin
      if (word_hit(aw_addr_r, addr_display_ctrl)) display_ctrl_r <= w_data_r[2:0];
      if (word_hit(aw_addr_r, addr_duty_clock_ctrl)) duty_clock_ctrl_r <= w_data_r[3:0];
      if (word_hit(aw_addr_r, addr_segment_port_select)) segment_port_select_r <= w_data_r[3:0];
      if (word_hit(aw_addr_r, addr_timer_mode)) timer_mode_r <= w_data_r[3:0];
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  // Write-only registers read as zero; status shows live state
  always_comb begin
    read_word = 32'h00000000;
    read_ok = 1'b1;
    if (word_hit(s_axi_araddr[9:0], addr_status)) begin
      read_word = {24'h000000, 1'b0, power_switch_on, common_index, segment_port_enable};
    end else if (word_hit(s_axi_araddr[9:0], addr_segment_port_select) ||
                 word_hit(s_axi_araddr[9:0], addr_display_ctrl) ||
                 word_hit(s_axi_araddr[9:0], addr_duty_clock_ctrl) ||
                 word_hit(s_axi_araddr[9:0], addr_timer_mode)) begin
      read_word = 32'h00000000;
    end else begin
      read_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= axi_okay;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_ok ? axi_okay : axi_slverr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: test/lcd_frame_clock_properties.sv
`timescale 1ns/1ps
// --------
// Port checker
// --------
module lcd_frame_clock_properties
  import lcd_timing_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] general_port_out,
  input wire logic [15:0] segment_drive,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lcd_clk_tick,
  input wire logic frame_tick,
  input wire logic power_switch_on,
  input wire logic display_on,
  input wire logic [15:0] segment_line,
  input wire logic [3:0] segment_port_enable
);
  logic rd_sel_r;

  // Read in flight targets the select register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_sel_r <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_sel_r <= s_axi_araddr[9:0] == addr_segment_port_select;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Select and blank settled for two cycles
  sequence s_steady;
    $past(aresetn) && $past(aresetn, 2) && $past(display_on, 2) == display_on &&
      $past(segment_port_enable, 2) == segment_port_enable;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_seg_low_nibble: assert property (s_steady ##0 segment_port_enable[0] |->
    segment_line[3:0] == (display_on ? $past(segment_drive[3:0]) : 4'h0)) else $error("segment nibble 0 wrong");
  a_port_high_nibble: assert property (s_steady ##0 !segment_port_enable[3] |->
    segment_line[15:12] == {4{$past(general_port_out[3])}}) else $error("port nibble 3 wrong");
  a_power_by_write: assert property ($changed(power_switch_on) |-> $past(s_axi_bvalid))
    else $error("power switch moved without a write");
  a_select_by_write: assert property ($changed(segment_port_enable) || $changed(display_on) |->
    $past(s_axi_bvalid)) else $error("select moved without a write");
  a_frame_on_tick: assert property (frame_tick |->
    lcd_clk_tick || $past(lcd_clk_tick) || $past(lcd_clk_tick, 2)) else $error("frame without clock tick");
  a_tick_single: assert property (lcd_clk_tick |=> !lcd_clk_tick [*8])
    else $error("clock ticks too close");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid) else $error("no write response");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_read_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid) else $error("no read response");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_zero: assert property (s_axi_rvalid && rd_sel_r |-> s_axi_rdata == 32'h0)
    else $error("select register read back");
endmodule

bind lcd_frame_clock lcd_frame_clock_properties props (.aclk, .aresetn, .general_port_out, .segment_drive,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .lcd_clk_tick, .frame_tick,
  .power_switch_on, .display_on, .segment_line, .segment_port_enable);

// file: test/lcd_panel_model.sv
`timescale 1ns/1ps
// Glass side: counts frames, guards the drive voltage
module lcd_panel_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_tick,
  input wire logic power_switch_on,
  input wire logic [7:0] lcd_drive_voltage,
  output logic voltage_fault,
  output logic [15:0] frame_count
);
  logic [7:0] voltage_r;

  // Voltage change with the divider switch closed
  always_ff @(posedge aclk) begin
    voltage_r <= lcd_drive_voltage;
    if (!aresetn) begin
      voltage_fault <= 1'b0;
    end else if (lcd_drive_voltage != voltage_r && power_switch_on) begin
      voltage_fault <= 1'b1;
    end
  end

  // Frames seen by the glass
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_count <= 16'h0;
    end else if (frame_tick) begin
      frame_count <= frame_count + 16'h1;
    end
  end
endmodule

// file: test/lcd_frame_clock_bench.sv
`timescale 1ns/1ps
module lcd_frame_clock_bench import lcd_timing_pkg::*;;
  // Oscillator runs fast to keep long divisions short
  localparam int osc_period = 8;
  localparam int timeout_cycles = 80000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [2:0] osc_cnt = 3'h0;
  logic osc_32k;
  logic [3:0] general_port_out = 4'h0;
  logic [15:0] segment_drive = 16'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lcd_clk_tick, frame_tick;
  logic power_switch_on, display_on, watch_display_on, voltage_fault;
  logic [1:0] s_axi_bresp, s_axi_rresp, common_index, r;
  logic [15:0] segment_line, frame_count;
  logic [3:0] segment_port_enable;
  logic [7:0] lcd_drive_voltage = 8'h0;
  logic [3:0] sel_list [4] = '{4'h5, 4'ha, 4'h0, 4'hf};
  duty_e duty_list [4] = '{duty_static, duty_half, duty_third, duty_quarter};
  int fail_count = 0, samples_checked = 0, cycles = 0, n;

  lcd_frame_clock dut (.aclk, .aresetn, .osc_32k, .general_port_out, .segment_drive, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .lcd_clk_tick, .frame_tick, .common_index, .power_switch_on, .display_on, .watch_display_on,
    .segment_line, .segment_port_enable);
  lcd_panel_model panel (.aclk, .aresetn, .frame_tick, .power_switch_on, .lcd_drive_voltage, .voltage_fault,
    .frame_count);

  // --------
  // Clock, oscillator, watchdog
  // --------
  initial begin
    forever #50 aclk = ~aclk;
  end
  assign osc_32k = osc_cnt[2];
  always @(posedge aclk) begin
    osc_cnt <= osc_cnt + 3'h1;
    cycles <= cycles + 1;
    if (cycles == timeout_cycles) begin
      fail_count++;
      conclude();
    end
  end

  // --------
  // Bus and check tasks
  // --------
  task bus(input bit wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
           output logic [31:0] rd, output logic [1:0] rs);
    logic [4:0] hs;
    hs = 5'h0;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, a};
    s_axi_araddr <= {22'h0, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!(wr ? hs[2] : hs[0])) begin
      @(negedge aclk);
      hs = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid, s_axi_bvalid & s_axi_bready,
            s_axi_arready & s_axi_arvalid, s_axi_rvalid & s_axi_rready};
      rd = s_axi_rdata;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (hs[4]) s_axi_awvalid <= 1'b0;
      if (hs[3]) s_axi_wvalid <= 1'b0;
      if (hs[2]) s_axi_bready <= 1'b0;
      if (hs[1]) s_axi_arvalid <= 1'b0;
      if (hs[0]) s_axi_rready <= 1'b0;
    end
  endtask

  task wreg(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, q, r);
    repeat (2) @(negedge aclk);
  endtask

  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  // Cycles between the second and third pulse
  task gap(input bit frm, output int cnt);
    for (int k = 0; k < 3; k++) begin
      cnt = 0;
      do begin
        @(negedge aclk);
        cnt++;
      end while (!(frm ? frame_tick : lcd_clk_tick));
    end
  endtask

  // Selected LCD clock ticks seen within a window of cycles
  task ticks_in(input int len, output int cnt);
    cnt = 0;
    repeat (len) begin
      @(negedge aclk);
      if (lcd_clk_tick) cnt++;
    end
  endtask

  function automatic logic [15:0] seg_exp(input logic [3:0] sel, gp, input logic [15:0] drv, input logic on);
    for (int i = 0; i < 4; i++) begin
      seg_exp[4*i +: 4] = sel[i] ? (on ? drv[4*i +: 4] : 4'h0) : {4{gp[i]}};
    end
  endfunction

  task done(input string name);
    $display("test %s finished", name);
  endtask

  task conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // --------
  // Test sequence
  // --------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wreg(addr_display_ctrl, 32'h7);
    chk("power_switch_on", 1, power_switch_on);
    chk("display_on", 1, display_on);
    chk("watch_display_on", 1, watch_display_on);
    done("display_ctrl");
    @(posedge aclk);
    general_port_out <= 4'h6;
    segment_drive <= 16'hc3a5;
    for (int i = 0; i < 4; i++) begin
      wreg(addr_segment_port_select, {28'h0, sel_list[i]});
      chk("segment_line", seg_exp(sel_list[i], 4'h6, 16'hc3a5, 1'b1), segment_line);
      chk("segment_port_enable", sel_list[i], segment_port_enable);
    end
    bus(1'b0, addr_segment_port_select, 32'h0, 4'h0, q, r);
    chk("select_read", 0, q);
    bus(1'b0, addr_status, 32'h0, 4'h0, q, r);
    chk("status_select", 4'hf, q[3:0]);
    bus(1'b1, addr_segment_port_select, 32'h0, 4'h0, q, r);
    repeat (2) @(negedge aclk);
    chk("strobeless_write", 4'hf, segment_port_enable);
    bus(1'b0, 10'h3fc, 32'h0, 4'h0, q, r);
    chk("unmapped_rresp", axi_slverr, r);
    chk("unmapped_rdata", 0, q);
    bus(1'b1, 10'h3fc, 32'hffff_ffff, 4'hf, q, r);
    chk("unmapped_bresp", axi_slverr, r);
    wreg(addr_segment_port_select, 32'h5);
    wreg(addr_display_ctrl, 32'h2);
    chk("blank_line", seg_exp(4'h5, 4'h6, 16'hc3a5, 1'b0), segment_line);
    done("segment_select");
    // Open the switch before moving the drive voltage
    wreg(addr_display_ctrl, 32'h1);
    chk("power_switch_on", 0, power_switch_on);
    @(posedge aclk);
    lcd_drive_voltage <= 8'h5a;
    repeat (2) @(negedge aclk);
    chk("voltage_fault", 0, voltage_fault);
    done("drive_voltage");
    wreg(addr_duty_clock_ctrl, {28'h0, sel_osc_div64, duty_static});
    gap(1'b0, n);
    chk("osc_div64", div_osc_clk0 * osc_period, n);
    for (int i = 0; i < 4; i++) begin
      wreg(addr_duty_clock_ctrl, {28'h0, sel_osc_div64, duty_list[i]});
      gap(1'b1, n);
      chk("frame_period", (i + 1) * div_osc_clk0 * osc_period, n);
    end
    chk("frames_seen", 1, |frame_count);
    chk("common_at_frame", 0, common_index);
    done("frame_rate");
    // Keep the source switch clear of the oscillator tick
    repeat (64) @(negedge aclk);
    wreg(addr_duty_clock_ctrl, {28'h0, sel_cyc_div256, duty_static});
    gap(1'b0, n);
    chk("cyc_div256", div_cyc_clk1 * cyc_div_cycles, n);
    wreg(addr_timer_mode, 32'h8);
    wreg(addr_duty_clock_ctrl, {28'h0, sel_fourth, duty_static});
    gap(1'b0, n);
    chk("osc_div512", div_osc_clk3 * osc_period, n);
    // Mode bit clear: fourth option leaves the oscillator
    wreg(addr_timer_mode, 32'h0);
    ticks_in(2 * div_osc_clk3 * osc_period, n);
    chk("cyc_div4096_slow", 1, n < 2);
    wreg(addr_duty_clock_ctrl, {28'h0, sel_cyc_div2048, duty_static});
    ticks_in(2 * div_cyc_clk1 * cyc_div_cycles, n);
    chk("cyc_div2048_slow", 1, n < 2);
    done("lcd_clock");
    conclude();
  end
endmodule
